// *** rtl/mmt_timer.sv ***
/*
  16-bit multi-mode timer with an AXI4-Lite register slave. One-shot,
  continuous, counter and capture/compare modes, a toggling output pin and a
  one-cycle interrupt pulse. Assumes one 200 MHz clock, a synchronous
  active-low reset and a timer input pin from outside the clock domain.
*/
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "mmt_cfg.svh"

module mmt_timer
  import mmt_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        timer_in,
  output logic             timer_out,
  output logic             timer_irq
);

  mmt_state_s st;
  mmt_state_s next_st;

  logic        tick;
  logic        edge_seen;
  logic        hit;
  logic        do_write;
  logic [11:0] raddr;
  logic [31:0] wd;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [6:0]  pre_max;

  assign s_axi_awready = !st.aw_done && !st.bvalid;
  assign s_axi_wready  = !st.w_done && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign timer_out     = st.out_lvl;
  assign timer_irq     = st.irq;

  // Prescale is a power of two, 1 to 128
  assign pre_max   = 7'((8'h01 << st.pre) - 8'h01);
  assign raddr     = s_axi_araddr;

  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (raddr)
      `MMT_OFF_CTL: begin
        rd_word[`MMT_CTL_EN]                      = st.en;
        rd_word[`MMT_CTL_MODE_LO +: 2]            = st.mode;
        rd_word[`MMT_CTL_POL]                     = st.pol;
        rd_word[`MMT_CTL_PRE_LO +: 3]             = st.pre;
        rd_word[`MMT_CTL_OUTEN]                   = st.outen;
      end
      `MMT_OFF_CTL2: begin
        rd_word[`MMT_CTL2_CAPF]                   = st.capf;
        rd_word[`MMT_CTL2_SRC_LO +: 2]            = st.src;
      end
      `MMT_OFF_COUNT:   rd_word[15:0] = st.count;
      `MMT_OFF_RELOAD:  rd_word[15:0] = st.reload;
      `MMT_OFF_CAPTURE: rd_word[15:0] = st.capture;
      default:          rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    next_st   = st;
    tick      = 1'b0;
    edge_seen = 1'b0;
    hit       = 1'b0;
    do_write  = 1'b0;
    wd        = 32'h0000_0000;

    // Input synchroniser; only the second stage feeds edge detection
    next_st.in_s1   = timer_in;
    next_st.in_s2   = st.in_s1;
    next_st.in_prev = st.in_s2;
    edge_seen = st.pol ? (st.in_s2 && !st.in_prev) : (!st.in_s2 && st.in_prev);
    next_st.irq = 1'b0;

    if (st.en) begin
      unique case (st.mode)
        mmt_counter: begin
          next_st.pre_cnt = 7'h00;
          if (edge_seen) begin
            if (st.count == st.reload) begin
              next_st.count = `MMT_COUNT_RESTART;
              hit = 1'b1;
            end else begin
              next_st.count = st.count + 16'h0001;
            end
          end
        end
        mmt_capture: begin
          if (!st.armed) begin
            if (edge_seen) begin
              next_st.armed = 1'b1;
            end
          end else if (edge_seen) begin
            next_st.capture = st.count;
            next_st.count   = `MMT_COUNT_RESTART;
            next_st.pre_cnt = 7'h00;
            next_st.capf    = 1'b1;
            next_st.irq     = (st.src != mmt_src_reload);
          end else begin
            tick = 1'b1;
          end
        end
        default: tick = 1'b1;
      endcase
    end

    if (tick) begin
      if (st.pre_cnt == pre_max) begin
        next_st.pre_cnt = 7'h00;
        if (st.count == st.reload) begin
          hit = 1'b1;
          next_st.count = `MMT_COUNT_RESTART;
          if (st.mode == mmt_one_shot) begin
            next_st.en    = 1'b0;
            next_st.armed = 1'b0;
          end
          if (st.mode == mmt_capture) begin
            next_st.capf = 1'b0;
          end
        end else begin
          next_st.count = st.count + 16'h0001;
        end
      end else begin
        next_st.pre_cnt = st.pre_cnt + 7'h01;
      end
    end

    if (hit) begin
      next_st.irq = (st.mode != mmt_capture) || (st.src != mmt_src_input);
      if (st.outen) begin
        next_st.out_lvl = !st.out_lvl;
      end
    end

    // AXI write channel
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_done = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_done = 1'b1;
      next_st.w_data = s_axi_wdata;
    end
    if (next_st.aw_done && next_st.w_done && !st.bvalid) begin
      do_write = 1'b1;
      wd       = next_st.w_data;
      next_st.aw_done = 1'b0;
      next_st.w_done  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = `MMT_RESP_OKAY;
      // Byte lane 0 carries all control fields; only the control write checks its strobe, the other registers ignore wstrb
      unique case (next_st.aw_addr)
        `MMT_OFF_CTL: if (s_axi_wstrb[0] || !s_axi_wvalid) begin
          next_st.en      = wd[`MMT_CTL_EN];
          next_st.mode    = mmt_mode_e'(wd[`MMT_CTL_MODE_LO +: 2]);
          next_st.pol     = wd[`MMT_CTL_POL];
          next_st.pre     = wd[`MMT_CTL_PRE_LO +: 3];
          next_st.outen   = wd[`MMT_CTL_OUTEN];
          next_st.pre_cnt = 7'h00;
          if (!wd[`MMT_CTL_EN]) begin
            next_st.armed = 1'b0;
          end
        end
        `MMT_OFF_CTL2:    next_st.src     = mmt_src_e'(wd[`MMT_CTL2_SRC_LO +: 2]);
        `MMT_OFF_COUNT:   next_st.count   = wd[15:0];
        `MMT_OFF_RELOAD:  next_st.reload  = wd[15:0];
        `MMT_OFF_CAPTURE: next_st.capture = wd[15:0];
        default:          next_st.bresp   = `MMT_RESP_SLVERR;
      endcase
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // AXI read channel
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_word;
      next_st.rresp  = rd_ok ? `MMT_RESP_OKAY : `MMT_RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st        <= '0;
      st.mode   <= mmt_one_shot;
      st.src    <= mmt_src_both;
      st.count  <= `MMT_COUNT_RST;
      st.reload <= `MMT_RELOAD_RST;
    end else begin
      st <= next_st;
    end
  end

endmodule // mmt_timer

// *** rtl/mmt_cfg.svh ***
/*
  Register offsets, field positions, reset values and fixed counts of the
  16-bit multi-mode timer. Assumes inclusion by bare name from the timer
  module and the bench top.
*/
`ifndef MMT_CFG_SVH
`define MMT_CFG_SVH

`define MMT_OFF_CTL      12'h000
`define MMT_OFF_CTL2     12'h004
`define MMT_OFF_COUNT    12'h008
`define MMT_OFF_RELOAD   12'h00c
`define MMT_OFF_CAPTURE  12'h010

`define MMT_CTL_EN       0
`define MMT_CTL_MODE_LO  1
`define MMT_CTL_POL      3
`define MMT_CTL_PRE_LO   4
`define MMT_CTL_OUTEN    7
`define MMT_CTL2_CAPF    0
`define MMT_CTL2_SRC_LO  1

`define MMT_COUNT_RESTART 16'h0001
`define MMT_COUNT_RST     16'h0000
`define MMT_RELOAD_RST    16'hffff

`define MMT_RESP_OKAY    2'b00
`define MMT_RESP_SLVERR  2'b10

`endif

// *** rtl/mmt_pkg.sv ***
/*
  Types of the 16-bit multi-mode timer: modes, interrupt-source choices and
  the packed state record. Assumes mmt_cfg.svh is on the include path.
*/
package mmt_pkg;
  typedef enum logic [1:0] {
    mmt_one_shot,
    mmt_continuous,
    mmt_counter,
    mmt_capture
  } mmt_mode_e;

  typedef enum logic [1:0] {
    mmt_src_both,
    mmt_src_input,
    mmt_src_reload,
    mmt_src_both_alt
  } mmt_src_e;

  typedef struct packed {
    logic        en;
    mmt_mode_e   mode;
    logic        pol;
    logic [2:0]  pre;
    logic        outen;
    logic        capf;
    mmt_src_e    src;
    logic [15:0] count;
    logic [15:0] reload;
    logic [15:0] capture;
    logic [6:0]  pre_cnt;
    logic        armed;
    logic        out_lvl;
    logic        irq;
    logic        in_s1;
    logic        in_s2;
    logic        in_prev;
    logic        aw_done;
    logic        w_done;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } mmt_state_s;
endpackage

// *** testbench/mmt_pin_src.sv ***
/* Source of the timer input pin. Assumes calls from the bench top. */
`timescale 1ns/1ps
module mmt_pin_src (
  input wire logic aclk,
  output logic     pin
);
  initial pin = 1'b0;
  // A half period of two clocks or more keeps the pin at a quarter rate or slower
  task automatic pulses(input int n, input int h);
    repeat (n) begin
      repeat (h) @(posedge aclk);
      pin <= 1'b1;
      repeat (h) @(posedge aclk);
      pin <= 1'b0;
    end
  endtask
endmodule // mmt_pin_src

// *** testbench/mmt_assertions.sv ***
/* Checker of bus answers and reset levels of the timer.
   Sees the top ports only; bound from the bench top file. */
`timescale 1ns/1ps
module mmt_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        timer_out,
  input wire logic        timer_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_write_answer: assert property (wr_taken |=> s_axi_bvalid) else $error("write unanswered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read unanswered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken");
  a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2}) else $error("bad code");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid
    && !timer_irq && !timer_out) else $error("busy in reset");
endmodule // mmt_checker

// *** testbench/tb_multi_mode_timer_16bit.sv ***
/* Bench of the timer through its register bus and input pin.
   Assumes the design, the pin source and the checker files. */
`timescale 1ns/1ps
`include "mmt_cfg.svh"
module tb_multi_mode_timer_16bit import mmt_pkg::*;;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [1:0] r;} mmt_row_s;
  mmt_row_s rows [6] = '{'{`MMT_OFF_CTL, 32'h0, 2'h0}, '{`MMT_OFF_CTL2, 32'h0, 2'h0},
    '{`MMT_OFF_COUNT, 32'h0, 2'h0}, '{`MMT_OFF_RELOAD, 32'hffff, 2'h0},
    '{`MMT_OFF_CAPTURE, 32'h0, 2'h0}, '{12'h020, 32'h0, `MMT_RESP_SLVERR}};
  wire         timer_in;
  logic        aclk = 1'b0, aresetn = 1'b0, timer_out, timer_irq, o;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv, rs;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int          n_errors = 0, checks = 0, t, lat;
  always #2.5 aclk = ~aclk;
  mmt_timer uut (.*);
  mmt_pin_src pin_src (.aclk(aclk), .pin(timer_in));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Handshakes are sampled at the falling edge, where the ready lines are settled
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic aw, wd, ar, vis, done;
    @(posedge aclk);
    if (w) begin
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
    end else begin
      {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    end
    repeat (99) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      wd = s_axi_wvalid && s_axi_wready;
      ar = s_axi_arvalid && s_axi_arready;
      vis = w ? s_axi_bvalid : s_axi_rvalid;
      done = vis && (s_axi_bready || s_axi_rready);
      rs = w ? s_axi_bresp : s_axi_rresp;
      rv = s_axi_rdata;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
      if (done) begin
        {s_axi_bready, s_axi_rready} <= 2'h0;
        return;
      end
      // Ready only after the answer shows, so a held answer is seen too
      if (vis) {s_axi_bready, s_axi_rready} <= {w, !w};
    end
    n_errors++;
    conclude();
  endtask
  task automatic wirq(output int n);
    for (n = 0; n < 5000; n++) begin
      @(negedge aclk);
      if (timer_irq) return;
    end
    n_errors++;
    conclude();
  endtask
  function automatic logic [31:0] ctl(input mmt_mode_e m, input logic p, input logic [2:0] pr, input logic oe);
    return {24'h0, oe, pr, p, m, 1'b0};
  endfunction
  task automatic arm(input logic [31:0] c, input logic [15:0] st, input logic [15:0] rl);
    bus(1'b1, `MMT_OFF_CTL, c);
    bus(1'b1, `MMT_OFF_COUNT, {16'h0, st});
    bus(1'b1, `MMT_OFF_RELOAD, {16'h0, rl});
    bus(1'b1, `MMT_OFF_CTL, c | 32'h1);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a, 32'h0);
      chk("reset data", rows[i].d, rv);
      chk("reset resp", {30'h0, rows[i].r}, rs);
    end
    bus(1'b1, 12'h020, 32'h1);
    chk("unmapped write", {30'h0, `MMT_RESP_SLVERR}, rs);
    arm(ctl(mmt_one_shot, 1'b0, 3'h1, 1'b0), 16'h0008, 16'h0018);
    wirq(lat);
    lat = lat - 32;
    chk("one-shot time", 32'h1, 32'(lat inside {[0:4]}));
    bus(1'b0, `MMT_OFF_CTL, 32'h0);
    chk("one-shot enable", 32'h0, {31'h0, rv[0]});
    bus(1'b1, `MMT_OFF_CTL, ctl(mmt_one_shot, 1'b1, 3'h1, 1'b0));
    bus(1'b0, `MMT_OFF_CTL, 32'h0);
    chk("polarity flip", 32'h1, {31'h0, rv[`MMT_CTL_POL]});
    arm(ctl(mmt_continuous, 1'b0, 3'h1, 1'b1), 16'h0004, 16'h0010);
    wirq(t);
    chk("first pass", 32'h1, 32'((t - lat) inside {[23:25]}));
    o = timer_out;
    wirq(t);
    chk("period", 32'h1f, t);
    chk("out toggle", {31'h0, ~o}, {31'h0, timer_out});
    wirq(t);
    chk("period", 32'h1f, t);
    arm(ctl(mmt_counter, 1'b1, 3'h7, 1'b0), 16'h0000, 16'h0003);
    fork
      pin_src.pulses(4, 4);
      wirq(t);
    join
    bus(1'b0, `MMT_OFF_COUNT, 32'h0);
    chk("edge count", 32'h1, rv);
    arm(ctl(mmt_capture, 1'b1, 3'h0, 1'b0), 16'h0000, 16'hffff);
    fork
      pin_src.pulses(2, 20);
      wirq(t);
    join
    bus(1'b0, `MMT_OFF_CAPTURE, 32'h0);
    chk("capture", 32'h1, 32'(rv inside {[38:42]}));
    bus(1'b0, `MMT_OFF_CTL2, 32'h0);
    chk("capture flag", 32'h1, rv);
    bus(1'b1, `MMT_OFF_RELOAD, 32'h0040);
    wirq(t);
    bus(1'b0, `MMT_OFF_CTL2, 32'h0);
    chk("compare flag", 32'h0, rv);
    conclude();
  end
endmodule // tb_multi_mode_timer_16bit
bind mmt_timer mmt_checker chk_i (.*);
